// *** pkg/jpe_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures of the
 * joystick parameter editor.
 * Assumes a 50 MHz system clock and 32-bit APB data with byte addresses.
 */
`ifndef JPE_REGS_SVH
`define JPE_REGS_SVH
// Register byte offsets.
`define JPE_CTRL 8'h00
`define JPE_MENU 8'h04
`define JPE_SCHED 8'h08
`define JPE_PCOUNT 8'h0C
`define JPE_LIMIDX 8'h10
`define JPE_LIMMIN 8'h14
`define JPE_LIMMAX 8'h18
`define JPE_VADDR 8'h1C
`define JPE_VDATA 8'h20
`define JPE_STATUS 8'h24
`define JPE_PAGE 8'h28
`define JPE_LOGREC 8'h2C
// Field positions.
`define JPE_CTRL_LOCK 0
`define JPE_CTRL_WELDSCR 1
`define JPE_CTRL_GAINSCR 2
`define JPE_CTRL_STATMODE 3
`define JPE_MENU_DEPTH_LSB 8
`define JPE_LIM_FLAG 16
`define JPE_ST_WELD 4
`define JPE_ST_GAIN 5
`define JPE_ST_DIRTY 7
`define JPE_ST_BUSY 8
`define JPE_ST_HELP 9
// Sizes and reset values.
`define JPE_NSCHED 100
`define JPE_SCHED_W 7
`define JPE_PARAM_W 4
`define JPE_VAL_W 16
`define JPE_ADDR_W 8
`define JPE_LOG_W 10
`define JPE_MENU_W 8
`define JPE_PAGE_W 3
`define JPE_PAGES 3'h7
`define JPE_WELD_LOG_PAGE 3'h2
`define JPE_ERR_LOG_PAGE 3'h3
`define JPE_WELD_RST 1'b0
`define JPE_PCT1_DIV 100
`define JPE_PCT5_DIV 20
// Timing.
`define JPE_CLK_MHZ 50
`define JPE_MSG_MS 3000
`define JPE_FLASH_MS 250
`define JPE_MS_CYC(ms) ((ms) * `JPE_CLK_MHZ * 1000)
`endif

// *** pkg/jpe_pkg.sv ***
/*
 * Types shared by the joystick parameter editor modules.
 * Assumes nothing of its surroundings.
 */
package jpe_pkg;
    // Adjust step size selected by the down toggle.
    typedef enum logic [1:0] {GAIN_ONE, GAIN_PCT1, GAIN_PCT5} jpe_gain_t;
    // Message shown on the help line.
    typedef enum logic [1:0] {HELP_NONE, HELP_FIRST, HELP_LAST} jpe_help_t;
    // Editor sequencing states.
    typedef enum logic [1:0] {ST_LOAD, ST_CAPT, ST_IDLE, ST_COMMIT} jpe_state_t;
endpackage

// *** pkg/jpe_step_if.sv ***
/*
 * Carrier between the editor and its step calculator.
 * Assumes the editor drives the user side and the calculator answers
 * combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
interface jpe_step_if #(parameter int VW = 16);
    logic [VW-1:0] cur;
    logic [VW-1:0] lo;
    logic [VW-1:0] hi;
    logic [VW-1:0] result;
    logic scaled;
    logic up;
    jpe_pkg::jpe_gain_t gain;
    modport calc(input cur, lo, hi, scaled, up, gain, output result);
    modport user(output cur, lo, hi, scaled, up, gain, input result);
endinterface
`default_nettype wire

// *** logic/jpe_mem.sv ***
/*
 * Simple memory with one write port and two registered read ports.
 * Assumes one clock; contents are undefined until written.
 */
`timescale 1ns/1ps
`default_nettype none
module jpe_mem #(
    parameter int DW = 16,
    parameter int AW = 11
) (
    // Clock.
    input wire logic sys_clk,
    // Write port.
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    // Read ports.
    input wire logic [AW-1:0] rdAddrA,
    output logic [DW-1:0] rdDataA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [DW-1:0] rdDataB
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Storage is left unreset so it maps onto block memory.
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Read data leave through registers.
    always_ff @(posedge sys_clk) begin
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end
endmodule // jpe_mem
`default_nettype wire

// *** logic/jpe_step.sv ***
/*
 * Step calculator: one rotation step up or down with gain and wraparound.
 * Assumes lo <= cur <= hi on its inputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "jpe_regs.svh"
module jpe_step #(
    parameter int VW = 16
) (
    // Operands and answer.
    jpe_step_if.calc st
);
    import jpe_pkg::*;
    logic [VW-1:0] step;
    logic [VW:0] sum;

    // A step never falls to zero, so small maxima still move.
    always_comb begin
        step = VW'(1);
        sum = '0;
        if (st.scaled && st.gain == GAIN_PCT1) begin
            step = VW'(st.hi / VW'(`JPE_PCT1_DIV));
        end else if (st.scaled && st.gain == GAIN_PCT5) begin
            step = VW'(st.hi / VW'(`JPE_PCT5_DIV));
        end
        if (step == '0) begin
            step = VW'(1);
        end
        if (st.up) begin
            sum = {1'b0, st.cur} + {1'b0, step};
            if (st.cur == st.hi) begin
                st.result = st.lo;
            end else if (sum > {1'b0, st.hi}) begin
                st.result = st.hi;
            end else begin
                st.result = sum[VW-1:0];
            end
        end else begin
            sum = {1'b0, st.lo} + {1'b0, step};
            if (st.cur == st.lo) begin
                st.result = st.hi;
            end else if ({1'b0, st.cur} < sum) begin
                st.result = st.lo;
            end else begin
                st.result = st.cur - step;
            end
        end
    end
endmodule // jpe_step
`default_nettype wire

// *** logic/jpe_editor.sv ***
/*
 * Joystick parameter editor: turns joystick actions into parameter edits
 * over a schedule memory and drives the title, help and main display state.
 * Assumes one-cycle joystick pulses synchronous to sys_clk and an APB
 * master for configuration and read-back.
 */
// The address map and the APB register port are this design's own decisions.
// Function
// - Store 100 schedules, selectable, readable and editable.
// - Left selects previous; at first, show message.
// - Up returns to parent or main menu.
// - Right selects next; at last, show message.
// - Down toggles weld and flashing no-weld state.
// - Down cycles gain: one, one percent, five.
// - Title flashes percent indicator for percent gains.
// - Clockwise raises value by gain step.
// - Raising the maximum wraps to minimum.
// - Counterclockwise lowers value by gain step.
// - Lowering the minimum wraps to maximum.
// - Push stores value, then selects next parameter.
// - Moving before push discards the rotated edit.
// - Seven read-only status pages; only log record changes.
// - Title shows menu, flashing lock; selection inverted.
`timescale 1ns/1ps
`default_nettype none
`include "jpe_regs.svh"
module jpe_editor #(
    parameter int NSCHED = `JPE_NSCHED,
    parameter int SW = `JPE_SCHED_W,
    parameter int PW = `JPE_PARAM_W,
    parameter int VW = `JPE_VAL_W,
    parameter int AW = `JPE_ADDR_W,
    parameter int LW = `JPE_LOG_W,
    parameter int MSG_CYCLES = `JPE_MS_CYC(`JPE_MSG_MS),
    parameter int FLASH_CYCLES = `JPE_MS_CYC(`JPE_FLASH_MS)
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Joystick actions, one-cycle pulses.
    input wire logic prevItemKey,
    input wire logic menuBackKey,
    input wire logic nextItemKey,
    input wire logic downKey,
    input wire logic adjustCw,
    input wire logic adjustCcw,
    input wire logic enterKey,
    // Display state.
    output logic [PW-1:0] selLine,
    output logic [VW-1:0] dispValue,
    output var jpe_pkg::jpe_help_t helpMsg,
    output logic [`JPE_MENU_W-1:0] titleMenu,
    output logic [1:0] menuDepth,
    output logic editLockIndicator,
    output var jpe_pkg::jpe_gain_t gainCode,
    output logic gainIndicator,
    output logic weldEnable,
    output logic noWeldFlash,
    output logic [`JPE_PAGE_W-1:0] statusPage,
    output logic [LW-1:0] logRecord
);
    import jpe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    jpe_state_t st;
    logic [PW-1:0] selIdx;
    logic [PW-1:0] lastIdx;
    logic [PW-1:0] limIdx;
    logic [PW-1:0] vaddr;
    logic [SW-1:0] sched;
    logic [VW-1:0] editValue;
    logic [VW-1:0] loVal;
    logic [VW-1:0] hiVal;
    logic [VW-1:0] limMinStage;
    logic scaled;
    logic dirty;
    logic lockEn;
    logic weldScr;
    logic gainScr;
    logic statusMode;
    jpe_gain_t gain;
    logic [31:0] helpTimer;
    logic [31:0] blinkCnt;
    logic blink;
    logic [VW-1:0] valRd;
    logic [VW-1:0] valRdB;
    logic [2*VW:0] limRd;
    logic apbWr;
    logic apbValWr;
    logic limWe;
    logic reloadReq;
    logic valWe;
    logic slowRd;
    logic evPush;
    logic evLeft;
    logic evRight;
    logic evUp;
    logic evDown;
    logic evCw;
    logic evCcw;
    logic atFirst;
    logic atLast;
    logic logPage;

    // Address map membership, used for the error answer; readReg decodes offsets itself.
    function automatic logic isMapped(input logic [AW-1:0] a);
        case (a)
            `JPE_CTRL, `JPE_MENU, `JPE_SCHED, `JPE_PCOUNT, `JPE_LIMIDX,
            `JPE_LIMMIN, `JPE_LIMMAX, `JPE_VADDR, `JPE_VDATA, `JPE_STATUS,
            `JPE_PAGE, `JPE_LOGREC: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Read data for a mapped offset; unmapped offsets read as zero.
    function automatic logic [31:0] readReg(input logic [AW-1:0] a);
        readReg = '0;
        case (a)
            `JPE_CTRL: readReg = (32'(lockEn) << `JPE_CTRL_LOCK)
                | (32'(weldScr) << `JPE_CTRL_WELDSCR)
                | (32'(gainScr) << `JPE_CTRL_GAINSCR)
                | (32'(statusMode) << `JPE_CTRL_STATMODE);
            `JPE_MENU: readReg = 32'(titleMenu)
                | (32'(menuDepth) << `JPE_MENU_DEPTH_LSB);
            `JPE_SCHED: readReg = 32'(sched);
            `JPE_PCOUNT: readReg = 32'(lastIdx);
            `JPE_LIMIDX: readReg = 32'(limIdx);
            `JPE_LIMMIN: readReg = 32'(limMinStage);
            `JPE_LIMMAX: readReg = 32'(hiVal) | (32'(scaled) << `JPE_LIM_FLAG);
            `JPE_VADDR: readReg = 32'(vaddr);
            `JPE_VDATA: readReg = 32'(valRdB);
            `JPE_STATUS: readReg = 32'(selIdx)
                | (32'(weldEnable) << `JPE_ST_WELD)
                | (32'(gain) << `JPE_ST_GAIN)
                | (32'(dirty) << `JPE_ST_DIRTY)
                | (32'(st != ST_IDLE) << `JPE_ST_BUSY)
                | (32'(helpMsg) << `JPE_ST_HELP);
            `JPE_PAGE: readReg = 32'(statusPage);
            `JPE_LOGREC: readReg = 32'(logRecord);
            default: readReg = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage: values per schedule and parameter, limits per parameter.
    assign apbWr = psel & penable & pready & pwrite;
    assign apbValWr = apbWr && (paddr == `JPE_VDATA);
    assign limWe = apbWr && (paddr == `JPE_LIMMAX);
    assign reloadReq = limWe || apbValWr || (apbWr && paddr == `JPE_SCHED);
    assign valWe = apbValWr || (st == ST_COMMIT);

    // Software writes win the port; a pending commit simply waits a cycle.
    jpe_mem #(.DW(VW), .AW(SW + PW)) u_values (
        .sys_clk(sys_clk),
        .wrEn(valWe),
        .wrAddr(apbValWr ? {sched, vaddr} : {sched, selIdx}),
        .wrData(apbValWr ? pwdata[VW-1:0] : editValue),
        .rdAddrA({sched, selIdx}),
        .rdDataA(valRd),
        .rdAddrB({sched, vaddr}),
        .rdDataB(valRdB)
    );

    // Limits: flag above maximum above minimum.
    jpe_mem #(.DW(2 * VW + 1), .AW(PW)) u_limits (
        .sys_clk(sys_clk),
        .wrEn(limWe),
        .wrAddr(limIdx),
        .wrData({pwdata[`JPE_LIM_FLAG], pwdata[VW-1:0], limMinStage}),
        .rdAddrA(selIdx),
        .rdDataA(limRd),
        .rdAddrB(selIdx),
        .rdDataB()
    );

    ////////////////////////////////////////////////////////////////////////
    // Joystick decode: one action per cycle, push first, only when idle.
    always_comb begin
        evPush = (st == ST_IDLE) && enterKey && !statusMode;
        evLeft = (st == ST_IDLE) && prevItemKey && !enterKey;
        evRight = (st == ST_IDLE) && nextItemKey && !enterKey && !prevItemKey;
        evUp = (st == ST_IDLE) && menuBackKey
            && !(enterKey || prevItemKey || nextItemKey);
        evDown = (st == ST_IDLE) && downKey
            && !(enterKey || prevItemKey || nextItemKey || menuBackKey);
        evCw = (st == ST_IDLE) && adjustCw
            && !(enterKey || prevItemKey || nextItemKey || menuBackKey || downKey);
        evCcw = (st == ST_IDLE) && adjustCcw && !adjustCw
            && !(enterKey || prevItemKey || nextItemKey || menuBackKey || downKey);
        atFirst = statusMode ? (statusPage == '0) : (selIdx == '0);
        atLast = statusMode ? (statusPage == `JPE_PAGES - 3'h1) : (selIdx == lastIdx);
        logPage = (statusPage == `JPE_WELD_LOG_PAGE) || (statusPage == `JPE_ERR_LOG_PAGE);
    end

    // Step calculator hookup.
    jpe_step_if #(.VW(VW)) stepBus ();
    assign stepBus.cur = editValue;
    assign stepBus.lo = loVal;
    assign stepBus.hi = hiVal;
    assign stepBus.scaled = scaled;
    assign stepBus.gain = gain;
    assign stepBus.up = evCw;
    jpe_step #(.VW(VW)) u_step (
        .st(stepBus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Editor sequence: load the stored value, edit it, commit or discard.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= ST_LOAD;
            selIdx <= '0;
            editValue <= '0;
            loVal <= '0;
            hiVal <= '0;
            scaled <= 1'b0;
            dirty <= 1'b0;
        end else if (reloadReq && st != ST_COMMIT) begin
            st <= ST_LOAD;
        end else begin
            case (st)
                ST_LOAD: begin
                    st <= ST_CAPT;
                end
                ST_CAPT: begin
                    editValue <= valRd;
                    {scaled, hiVal, loVal} <= limRd;
                    dirty <= 1'b0;
                    st <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (evPush) begin
                        st <= ST_COMMIT;
                    end else if (evLeft && !statusMode && !atFirst) begin
                        selIdx <= selIdx - PW'(1);
                        st <= ST_LOAD;
                    end else if (evRight && !statusMode && !atLast) begin
                        selIdx <= selIdx + PW'(1);
                        st <= ST_LOAD;
                    end else if ((evCw || evCcw) && !statusMode) begin
                        editValue <= stepBus.result;
                        dirty <= 1'b1;
                    end
                end
                ST_COMMIT: begin
                    // The value memory writes in this state unless software owns it.
                    if (!apbValWr) begin
                        if (selIdx != lastIdx) begin
                            selIdx <= selIdx + PW'(1);
                        end
                        st <= ST_LOAD;
                    end
                end
                default: begin
                    st <= ST_LOAD;
                end
            endcase
        end
    end

    // Boundary messages stay for a fixed time, then clear themselves.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            helpMsg <= HELP_NONE;
            helpTimer <= '0;
        end else if (evLeft && atFirst) begin
            helpMsg <= HELP_FIRST;
            helpTimer <= 32'(MSG_CYCLES - 1);
        end else if (evRight && atLast) begin
            helpMsg <= HELP_LAST;
            helpTimer <= 32'(MSG_CYCLES - 1);
        end else if (helpMsg != HELP_NONE) begin
            if (helpTimer == '0) begin
                helpMsg <= HELP_NONE;
            end else begin
                helpTimer <= helpTimer - 32'h1;
            end
        end
    end

    // Down toggle: weld state on weld screens, gain elsewhere where allowed.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            weldEnable <= `JPE_WELD_RST;
            gain <= GAIN_ONE;
        end else if (evDown && !statusMode) begin
            if (weldScr) begin
                weldEnable <= !weldEnable;
            end else if (gainScr) begin
                case (gain)
                    GAIN_ONE: gain <= GAIN_PCT1;
                    GAIN_PCT1: gain <= GAIN_PCT5;
                    default: gain <= GAIN_ONE;
                endcase
            end
        end
    end

    // Menu level: software enters menus, the up toggle climbs back out.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            titleMenu <= '0;
            menuDepth <= '0;
        end else if (apbWr && paddr == `JPE_MENU) begin
            titleMenu <= pwdata[`JPE_MENU_W-1:0];
            menuDepth <= pwdata[`JPE_MENU_DEPTH_LSB+1:`JPE_MENU_DEPTH_LSB];
        end else if (evUp && menuDepth != '0) begin
            menuDepth <= menuDepth - 2'h1;
        end
    end

    // Status pages never edit parameters; rotation only picks a log record.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            statusPage <= '0;
            logRecord <= '0;
        end else if (apbWr && paddr == `JPE_PAGE) begin
            if (pwdata[`JPE_PAGE_W-1:0] < `JPE_PAGES) begin
                statusPage <= pwdata[`JPE_PAGE_W-1:0];
            end
        end else if (statusMode) begin
            if (evLeft && !atFirst) begin
                statusPage <= statusPage - 3'h1;
            end else if (evRight && !atLast) begin
                statusPage <= statusPage + 3'h1;
            end else if (evCw && logPage) begin
                logRecord <= logRecord + LW'(1);
            end else if (evCcw && logPage) begin
                logRecord <= logRecord - LW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash clock and registered display outputs.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            blinkCnt <= '0;
            blink <= 1'b0;
        end else if (blinkCnt == 32'(FLASH_CYCLES - 1)) begin
            blinkCnt <= '0;
            blink <= !blink;
        end else begin
            blinkCnt <= blinkCnt + 32'h1;
        end
    end

    // Indicators follow the flash one cycle late, which nobody can see.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            editLockIndicator <= 1'b0;
            gainIndicator <= 1'b0;
            gainCode <= GAIN_ONE;
            noWeldFlash <= 1'b0;
            selLine <= '0;
            dispValue <= '0;
        end else begin
            editLockIndicator <= lockEn && blink;
            gainIndicator <= (gain != GAIN_ONE) && blink;
            gainCode <= gain;
            noWeldFlash <= !weldEnable && blink;
            selLine <= selIdx;
            dispValue <= editValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written control registers.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lockEn <= 1'b0;
            weldScr <= 1'b0;
            gainScr <= 1'b0;
            statusMode <= 1'b0;
            sched <= '0;
            lastIdx <= '0;
            limIdx <= '0;
            limMinStage <= '0;
            vaddr <= '0;
        end else if (apbWr) begin
            case (paddr)
                `JPE_CTRL: begin
                    lockEn <= pwdata[`JPE_CTRL_LOCK];
                    weldScr <= pwdata[`JPE_CTRL_WELDSCR];
                    gainScr <= pwdata[`JPE_CTRL_GAINSCR];
                    statusMode <= pwdata[`JPE_CTRL_STATMODE];
                end
                `JPE_SCHED: begin
                    if (int'(pwdata[SW-1:0]) < NSCHED) begin
                        sched <= pwdata[SW-1:0];
                    end
                end
                `JPE_PCOUNT: lastIdx <= pwdata[PW-1:0];
                `JPE_LIMIDX: limIdx <= pwdata[PW-1:0];
                `JPE_LIMMIN: limMinStage <= pwdata[VW-1:0];
                `JPE_VADDR: vaddr <= pwdata[PW-1:0];
                default: begin
                end
            endcase
        end
    end

    // Value reads wait one cycle so a new value address reaches the memory.
    assign slowRd = (paddr == `JPE_VDATA) && !pwrite;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !pready && (penable || !slowRd)) begin
            pready <= 1'b1;
            prdata <= pwrite ? '0 : readReg(paddr);
            pslverr <= !isMapped(paddr);
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // jpe_editor
`default_nettype wire

// *** dv/jpe_monitor.sv ***
/* Port checker for the editor.
   Assumes it is bound to jpe_editor. */
`timescale 1ns/1ps
`default_nettype none
module jpe_monitor (
    // Clock, reset and bus.
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Display state.
    input wire logic [1:0] menuDepth,
    input var jpe_pkg::jpe_gain_t gainCode,
    input wire logic gainIndicator,
    input wire logic weldEnable,
    input wire logic noWeldFlash,
    input wire logic [2:0] statusPage
);
    import jpe_pkg::*;
    // All checks share one clock and the reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_ack; psel && !penable && {pwrite, paddr} != 9'h20 |=> pready; endproperty
    a_ack: assert property (p_ack) else $error("late answer");
    property p_vd; psel && !penable && {pwrite, paddr} == 9'h20 |=> !pready ##1 pready; endproperty
    a_vd: assert property (p_vd) else $error("value read timing");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_err; pslverr |-> pready && (paddr > 8'h2C || paddr[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_page; statusPage <= 3'h6; endproperty
    a_page: assert property (p_page) else $error("bad page");
    property p_gain;
        $changed(gainCode) |-> 2'(gainCode) == (($past(gainCode) == GAIN_PCT5) ? 2'h0
            : 2'($past(gainCode) + 2'h1));
    endproperty
    a_gain: assert property (p_gain) else $error("gain order");
    property p_gind; gainCode == GAIN_ONE && $past(gainCode) == GAIN_ONE |-> !gainIndicator; endproperty
    a_gind: assert property (p_gind) else $error("gain mark");
    property p_weld; weldEnable && $past(weldEnable) |-> !noWeldFlash; endproperty
    a_weld: assert property (p_weld) else $error("weld text");
    property p_depth;
        $changed(menuDepth) && !$past(pready && pwrite) && !$past(pready && pwrite, 2)
            |-> menuDepth == 2'($past(menuDepth) - 2'h1);
    endproperty
    a_depth: assert property (p_depth) else $error("menu depth");
    c_pct5: cover property (gainCode == GAIN_PCT5);
    c_weld: cover property (weldEnable);
    c_err: cover property (pslverr);
endmodule // jpe_monitor
////////
bind jpe_editor jpe_monitor jpe_monitor_i (.*);
`default_nettype wire

// *** dv/jpe_joystick.sv ***
/* Operator joystick model.
   Assumes the bench asks for one action at a time. */
`timescale 1ns/1ps
`default_nettype none
module jpe_joystick (
    // Request from the bench.
    input wire logic sys_clk,
    input wire logic go,
    input wire logic [2:0] act,
    // Joystick actions.
    output logic enterKey,
    output logic prevItemKey,
    output logic nextItemKey,
    output logic menuBackKey,
    output logic downKey,
    output logic adjustCw,
    output logic adjustCcw
);
    logic [6:0] keys = 7'h00;
    // One detent or toggle gives exactly one single-cycle pulse.
    always @(posedge sys_clk) begin
        keys <= go ? 7'h40 >> act : 7'h00;
    end
    assign {enterKey, prevItemKey, nextItemKey, menuBackKey, downKey, adjustCw, adjustCcw} = keys;
endmodule // jpe_joystick
`default_nettype wire

// *** dv/test_joystick_parameter_editor.sv ***
/* Self-checking bench for the editor.
   Assumes the monitor is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_joystick_parameter_editor;
    import jpe_pkg::*;
    localparam int LO = 10, HI = 200;
    logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00, titleMenu;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] act = 3'h0, statusPage;
    logic pready, pslverr, err, editLockIndicator, gainIndicator, weldEnable, noWeldFlash;
    logic prevItemKey, menuBackKey, nextItemKey, downKey, adjustCw, adjustCcw, enterKey;
    logic [3:0] selLine;
    logic [15:0] dispValue;
    logic [1:0] menuDepth;
    logic [9:0] logRecord;
    jpe_help_t helpMsg;
    jpe_gain_t gainCode;
    int failCount = 0, numChecks = 0, v, g = 0, k;
    int ops[] = '{5, 6, 4, 6, 4, 6, 5, 5, 5, 4};
    always #10 sys_clk = ~sys_clk;
    jpe_editor #(.MSG_CYCLES(20), .FLASH_CYCLES(4)) jpe_editor_i (.*);
    jpe_joystick jpe_joystick_i (.*);
    ////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; the wait is bounded so a dead slave ends the run.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failCount++;
            printVerdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Idle gap lets any reload finish before the action lands.
    task automatic key(input logic [2:0] a);
        repeat (4) @(posedge sys_clk);
        act <= a;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask
    function automatic int step(int c, bit up, int gn);
        int s = (gn == 2) ? HI / 20 : ((gn == 1) ? HI / 100 : 1);
        if (up) return (c == HI) ? LO : ((c + s > HI) ? HI : c + s);
        return (c == LO) ? HI : ((c - s < LO) ? LO : c - s);
    endfunction
    ////////
    initial begin
        void'($urandom(49));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h14, LO);
        apb(1'b1, 8'h18, 32'h10000 | HI);
        apb(1'b1, 8'h20, HI);
        v = HI;
        foreach (ops[i]) begin
            key(3'(ops[i]));
            if (ops[i] == 4) g = (g + 1) % 3;
            else v = step(v, ops[i] == 5, g);
            check(dispValue, v);
            check(gainCode, g);
        end
        apb(1'b1, 8'h18, HI); // Unflagged now, so the gain set next must not matter.
        key(3'h4);
        repeat (4) begin
            v = LO + $urandom % (HI - LO + 1);
            apb(1'b1, 8'h20, v);
            k = 5 + $urandom % 2;
            key(3'(k));
            v = step(v, k == 5, 0);
            check(dispValue, v);
        end
        $display("stepping done");
        key(3'h1);
        check(helpMsg, HELP_FIRST);
        key(3'h5);
        v = step(v, 1'b1, g);
        key(3'h0);
        check(selLine, 1);
        apb(1'b0, 8'h20, 0);
        check(rd, v);
        key(3'h1);
        key(3'h5);
        key(3'h2);
        key(3'h1);
        check(dispValue, v);
        repeat (3) key(3'h2);
        check(helpMsg, HELP_LAST);
        $display("moves done");
        apb(1'b1, 8'h04, 32'h200);
        key(3'h3);
        check(menuDepth, 1);
        apb(1'b1, 8'h00, 32'h2);
        key(3'h4);
        check(weldEnable, 1);
        apb(1'b0, 8'h30, 0);
        check(err, 1);
        $display("menus done");
        printVerdict();
    end
endmodule // test_joystick_parameter_editor
`default_nettype wire
